// *** design/cfhr_regs.sv ***
// Overflow flags, PLL divider, filter controls and headset detection registers.
`timescale 1ns/10ps
`default_nettype none
module cfhr_regs
  import cfhr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Overflow events from the converters.
  input wire logic i_ovf_adc_l,
  input wire logic i_ovf_adc_r,
  input wire logic i_ovf_dac_l,
  input wire logic i_ovf_dac_r,
  // Headset contacts, asynchronous.
  input wire logic i_jack_in,
  input wire logic i_mic_in,
  input wire logic i_button_in,
  // Control outputs.
  output logic [4:0] o_pll_ratio,
  output logic [1:0] o_hpf_left,
  output logic [1:0] o_hpf_right,
  output logic o_dac_fx_left,
  output logic o_dac_deemph_left,
  output logic o_dac_fx_right,
  output logic o_dac_deemph_right,
  output logic [1:0] o_headset_type,
  output logic o_button_flag
);

  logic [3:0] ovf_q, ovf_d;
  logic [3:0] pll_q;
  logic [7:0] filt_q;
  logic det_en_q;
  logic [2:0] jdeb_q;
  logic [1:0] bdeb_q;
  logic [1:0] type_q;
  logic btn_flag_q, btn_flag_d;
  logic [4:0] ratio_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [2:0] pin_meta_q, pin_sync_q;
  logic [16:0] tick_cnt_q;
  logic [6:0] jdiv_q, bdiv_q;
  logic [1:0] jstab_q, jcand_q;
  logic [3:0] jcnt_q;
  logic bstab_q, bcand_q;
  logic [3:0] bcnt_q;

  // Register decode.
  wire wr_ovf = i_reg_wr && (i_reg_addr == ADDR_OVF_PLL);
  wire wr_filt = i_reg_wr && (i_reg_addr == ADDR_FILT);
  wire wr_hsd = i_reg_wr && (i_reg_addr == ADDR_HSD_A);
  wire rd_ovf = i_reg_rd && (i_reg_addr == ADDR_OVF_PLL);
  wire rd_hsdb = i_reg_rd && (i_reg_addr == ADDR_HSD_B);
  wire [3:0] ovf_evt = {i_ovf_adc_l, i_ovf_adc_r, i_ovf_dac_l, i_ovf_dac_r};
  wire [7:0] hsdb_word = {2'h0, btn_flag_q, type_q != TYPE_NONE, 4'h0};
  wire [7:0] rd_mux = (i_reg_addr == ADDR_OVF_PLL) ? {ovf_q, pll_q} :
                      (i_reg_addr == ADDR_FILT) ? filt_q :
                      (i_reg_addr == ADDR_HSD_A) ? {det_en_q, type_q, jdeb_q, bdeb_q} :
                      (i_reg_addr == ADDR_HSD_B) ? hsdb_word : 8'h00;

  // Sticky flags: a new event in the clearing cycle wins over the read.
  assign ovf_d = (ovf_q & ~{4{rd_ovf}}) | ovf_evt;

  // Sample pacing; reserved jack codes are clamped to the slowest rate.
  wire [2:0] jcode = (jdeb_q > JDEB_MAX) ? JDEB_MAX : jdeb_q;
  wire [6:0] jper_m1 = (7'h02 << jcode) - 7'h01;
  wire [6:0] bper_m1 = (7'h01 << (bdeb_q - 2'h1)) - 7'h01;
  wire ms_tick = (tick_cnt_q == 17'(TICK_CYCLES - 1));
  wire jsamp = det_en_q && ms_tick && (jdiv_q == jper_m1);
  wire bsamp = det_en_q && ms_tick && (bdiv_q == bper_m1);

  // Debounce: a sample that differs from the stable level must repeat unchanged.
  wire [1:0] jraw = {pin_sync_q[2], pin_sync_q[2] & pin_sync_q[1]};
  wire jaccept = jsamp && (jraw != jstab_q) && (jraw == jcand_q)
                 && (jcnt_q == DEB_SAMPLES - 4'h1);
  wire bnodeb = det_en_q && (bdeb_q == 2'h0);
  wire baccept = bsamp && (bdeb_q != 2'h0) && (pin_sync_q[0] != bstab_q)
                 && (pin_sync_q[0] == bcand_q) && (bcnt_q == DEB_SAMPLES - 4'h1);
  wire bnext = bnodeb ? pin_sync_q[0] : (baccept ? pin_sync_q[0] : bstab_q);
  wire bpress = det_en_q && bnext && !bstab_q;
  assign btn_flag_d = (btn_flag_q & ~rd_hsdb) | bpress;
  wire [1:0] type_d = !jstab_q[1] ? TYPE_NONE : (jstab_q[0] ? TYPE_MIC : TYPE_NO_MIC);

  // Software-visible control state.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ovf_q <= RST_OVF;
      pll_q <= RST_PLL_DIV;
      filt_q <= RST_FILT;
      det_en_q <= 1'b0;
      jdeb_q <= 3'h0;
      bdeb_q <= 2'h0;
      btn_flag_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
      btn_flag_q <= btn_flag_d;
      if (wr_ovf) begin
        pll_q <= i_reg_wdata[PLL_MSB:0];
      end
      if (wr_filt) begin
        filt_q <= i_reg_wdata;
      end
      if (wr_hsd) begin
        det_en_q <= i_reg_wdata[DET_EN_BIT];
        jdeb_q <= i_reg_wdata[JDEB_MSB:JDEB_LSB];
        bdeb_q <= i_reg_wdata[BDEB_MSB:0];
      end
    end
  end

  // Read data and derived outputs are registered so each output is a flop.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      ratio_q <= 5'h01;
      type_q <= TYPE_NONE;
    end else begin
      rvalid_q <= i_reg_rd;
      if (i_reg_rd) begin
        rdata_q <= rd_mux;
      end
      ratio_q <= (pll_q == 4'h0) ? PLL_ZERO_RATIO : {1'b0, pll_q};
      type_q <= det_en_q ? type_d : TYPE_NONE;
    end
  end

  // Two-stage synchronisers for the jack, microphone and button contacts.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {i_jack_in, i_mic_in, i_button_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Millisecond base and per-detector sample dividers; idle while detection is off.
  always_ff @(posedge i_clk) begin
    if (i_reset || !det_en_q) begin
      tick_cnt_q <= 17'h0;
      jdiv_q <= 7'h0;
      bdiv_q <= 7'h0;
    end else begin
      tick_cnt_q <= ms_tick ? 17'h0 : tick_cnt_q + 17'h1;
      if (ms_tick) begin
        jdiv_q <= (jdiv_q >= jper_m1) ? 7'h0 : jdiv_q + 7'h1;
        bdiv_q <= (bdiv_q >= bper_m1) ? 7'h0 : bdiv_q + 7'h1;
      end
    end
  end

  // Jack debouncer: a mismatch or a change of candidate restarts the count.
  always_ff @(posedge i_clk) begin
    if (i_reset || !det_en_q) begin
      jstab_q <= 2'h0;
      jcand_q <= 2'h0;
      jcnt_q <= 4'h0;
    end else if (jsamp) begin
      jcand_q <= jraw;
      if (jraw == jstab_q) begin
        jcnt_q <= 4'h0;
      end else if (jaccept) begin
        jstab_q <= jraw;
        jcnt_q <= 4'h0;
      end else begin
        jcnt_q <= (jraw == jcand_q) ? jcnt_q + 4'h1 : 4'h1;
      end
    end
  end

  // Button debouncer; with debounce off the synchronised level is taken directly.
  always_ff @(posedge i_clk) begin
    if (i_reset || !det_en_q) begin
      bstab_q <= 1'b0;
      bcand_q <= 1'b0;
      bcnt_q <= 4'h0;
    end else begin
      bstab_q <= bnext;
      if (bnodeb || baccept || (bsamp && pin_sync_q[0] == bstab_q)) begin
        bcnt_q <= 4'h0;
      end else if (bsamp) begin
        bcnt_q <= (pin_sync_q[0] == bcand_q) ? bcnt_q + 4'h1 : 4'h1;
      end
      if (bsamp) begin
        bcand_q <= pin_sync_q[0];
      end
    end
  end

  // Outputs, all from flops.
  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_pll_ratio = ratio_q;
  assign o_hpf_left = filt_q[7:6];
  assign o_hpf_right = filt_q[5:4];
  assign o_dac_fx_left = filt_q[3];
  assign o_dac_deemph_left = filt_q[2];
  assign o_dac_fx_right = filt_q[1];
  assign o_dac_deemph_right = filt_q[0];
  assign o_headset_type = type_q;
  assign o_button_flag = btn_flag_q;

  // Any overflow event shows in its flag next cycle, and unread flags never drop.
  property p_ovf_sticky;
    @(posedge i_clk) disable iff (i_reset)
      ##1 ((ovf_q & $past(ovf_evt)) == $past(ovf_evt))
        && ($past(rd_ovf) || ((ovf_q & $past(ovf_q)) == $past(ovf_q)))
        && (o_reg_rvalid == $past(i_reg_rd));
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag not set");

  // A flag read with no new event returns to zero.
  property p_ovf_clear;
    @(posedge i_clk) disable iff (i_reset) (rd_ovf && ovf_evt == 4'h0) |=> ovf_q == 4'h0;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flags not cleared by read");

  // Code zero maps to ratio sixteen, others to themselves.
  property p_pll_ratio;
    @(posedge i_clk) disable iff (i_reset)
      ##1 o_pll_ratio == (($past(pll_q) == 4'h0) ? 5'h10 : {1'b0, $past(pll_q)});
  endproperty
  a_pll_ratio: assert property (p_pll_ratio) else $error("pll ratio mismatch");

  // Highpass codes follow a filter register write.
  property p_hpf;
    @(posedge i_clk) disable iff (i_reset)
      wr_filt |=> {o_hpf_left, o_hpf_right} == $past(i_reg_wdata[7:4]);
  endproperty
  a_hpf: assert property (p_hpf) else $error("highpass control not written");

  // Effects enables sit on bits 3 and 1.
  property p_fx;
    @(posedge i_clk) disable iff (i_reset)
      wr_filt |=> o_dac_fx_left == $past(i_reg_wdata[3])
        && o_dac_fx_right == $past(i_reg_wdata[1]);
  endproperty
  a_fx: assert property (p_fx) else $error("effects enable misplaced");

  // De-emphasis enables sit on bits 2 and 0.
  property p_deemph;
    @(posedge i_clk) disable iff (i_reset)
      wr_filt |=> o_dac_deemph_left == $past(i_reg_wdata[2])
        && o_dac_deemph_right == $past(i_reg_wdata[0]);
  endproperty
  a_deemph: assert property (p_deemph) else $error("de-emphasis enable misplaced");

  // With detection off the type reports none and the press flag cannot rise.
  // A button already held when detection is switched on may count as a press at once.
  property p_det_off;
    @(posedge i_clk) disable iff (i_reset)
      !det_en_q |=> o_headset_type == TYPE_NONE && !$rose(o_button_flag);
  endproperty
  a_det_off: assert property (p_det_off) else $error("detection active while disabled");

  // The reserved type code never appears.
  property p_type;
    @(posedge i_clk) disable iff (i_reset) o_headset_type != 2'h2;
  endproperty
  a_type: assert property (p_type) else $error("reserved headset type reported");

  // Jack state changes only on the sample that completes eight matching samples.
  property p_jack_accept;
    @(posedge i_clk) disable iff (i_reset)
      (det_en_q && jstab_q != $past(jstab_q)) |-> $past(jsamp) && $past(jcnt_q) == 4'h7;
  endproperty
  a_jack_accept: assert property (p_jack_accept)
    else $error("jack change without full debounce");

  // A debounced press sets the sticky flag.
  property p_btn_flag;
    @(posedge i_clk) disable iff (i_reset) bpress |=> o_button_flag;
  endproperty
  a_btn_flag: assert property (p_btn_flag) else $error("button flag not set");

endmodule : cfhr_regs
`default_nettype wire

// *** design/cfhr_pkg.sv ***
// Constants shared by the codec flag, filter and headset register group.
// Operation
// - Sticky overflow flags for left/right ADC and left/right DAC sit in bits 7 to 4.
// - A read of the flag register clears the overflow flags, which read 0 after reset.
// - PLL pre-divider bits 3-0 give ratio 16 for code 0, else the code, and reset to 1.
// - Left and right ADC highpass codes sit in bits 7-6 and 5-4, and 00 turns one off.
// - Bit 3 enables the left DAC effects filter and bit 1 the right one; 0 bypasses it.
// - Bit 2 enables left DAC de-emphasis and bit 0 the right one; filter bits reset to 0.
// - Detection runs only while bit 7 of the detection control is 1; it resets to 0.
// - Read-only bits 6-5 report type 00 none, 01 no microphone or 11 microphone, never 10.
// - Jack debounce in bits 4-2 selects 16 to 512 ms, sampled every 2 to 64 ms.
// - Button debounce in bits 1-0 selects none, 8 ms at 1 ms, 16 ms at 2 ms or 32 ms at 4 ms.
// - A button press sets a sticky flag that clears when its register is read.
package cfhr_pkg;
  // Register offsets on the codec control port.
  localparam logic [7:0] ADDR_OVF_PLL = 8'h0b;
  localparam logic [7:0] ADDR_FILT = 8'h0c;
  localparam logic [7:0] ADDR_HSD_A = 8'h0d;
  localparam logic [7:0] ADDR_HSD_B = 8'h0e;
  // Values after reset.
  localparam logic [3:0] RST_PLL_DIV = 4'h1;
  localparam logic [7:0] RST_FILT = 8'h00;
  localparam logic [3:0] RST_OVF = 4'h0;
  // Field positions.
  localparam int OVF_MSB = 7;
  localparam int OVF_LSB = 4;
  localparam int PLL_MSB = 3;
  localparam int DET_EN_BIT = 7;
  localparam int JDEB_MSB = 4;
  localparam int JDEB_LSB = 2;
  localparam int BDEB_MSB = 1;
  localparam int BTN_FLAG_BIT = 5;
  localparam int HS_FLAG_BIT = 4;
  // Encodings.
  localparam logic [4:0] PLL_ZERO_RATIO = 5'h10;
  localparam logic [1:0] TYPE_NONE = 2'h0;
  localparam logic [1:0] TYPE_NO_MIC = 2'h1;
  localparam logic [1:0] TYPE_MIC = 2'h3;
  localparam logic [2:0] JDEB_MAX = 3'h5;
  // Timing: one millisecond base tick at the core clock rate.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYC = TICK_TIME_NS / CLK_PERIOD_NS;
  // Every debounce period is eight sample intervals long.
  localparam logic [3:0] DEB_SAMPLES = 4'h8;
endpackage : cfhr_pkg

// *** dv/cfhr_contact_model.sv ***
// Headset jack, microphone and button contact model with contact bounce.
`timescale 1ns/10ps
`default_nettype none
module cfhr_contact_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Requested contact level and the bouncing pin.
  input wire logic i_req,
  output logic o_pin
);
  logic last_q;
  logic [2:0] bounce_q;
  // A real contact chatters after each change, so the pin toggles before it settles.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      last_q <= 1'b0;
      bounce_q <= 3'h0;
      o_pin <= 1'b0;
    end else begin
      last_q <= i_req;
      if (i_req != last_q) begin
        bounce_q <= 3'h5;
      end else if (bounce_q != 3'h0) begin
        bounce_q <= bounce_q - 3'h1;
      end
      o_pin <= (bounce_q != 3'h0) ? ~o_pin : last_q;
    end
  end
endmodule : cfhr_contact_model
`default_nettype wire

// *** dv/codec_flags_filter_headset_regs_tb.sv ***
// Self-checking testbench for the codec flag, filter and headset register group.
`timescale 1ns/10ps
`default_nettype none
module codec_flags_filter_headset_regs_tb;
  import cfhr_pkg::*;
  // A short base tick keeps the millisecond debounce periods affordable.
  localparam int TK = 4;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] ovf = 4'h0;
  logic jack_req = 1'b0;
  logic mic_req = 1'b0;
  logic btn_req = 1'b0;
  logic jack, mic, btn, rvalid, fx_l, de_l, fx_r, de_r, bflag;
  logic [7:0] rdata;
  logic [4:0] ratio;
  logic [1:0] hpf_l, hpf_r, htype;
  logic [7:0] fv [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
  int err_total = 0;
  int tests_run = 0;

  // Free-running core clock.
  initial begin
    forever #4 i_clk = ~i_clk;
  end

  cfhr_regs #(.TICK_CYCLES(TK)) dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_ovf_adc_l(ovf[3]), .i_ovf_adc_r(ovf[2]), .i_ovf_dac_l(ovf[1]), .i_ovf_dac_r(ovf[0]),
    .i_jack_in(jack), .i_mic_in(mic), .i_button_in(btn), .o_pll_ratio(ratio),
    .o_hpf_left(hpf_l), .o_hpf_right(hpf_r), .o_dac_fx_left(fx_l),
    .o_dac_deemph_left(de_l), .o_dac_fx_right(fx_r), .o_dac_deemph_right(de_r),
    .o_headset_type(htype), .o_button_flag(bflag));
  cfhr_contact_model jack_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(jack_req), .o_pin(jack));
  cfhr_contact_model mic_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(mic_req), .o_pin(mic));
  cfhr_contact_model btn_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(btn_req), .o_pin(btn));

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] got);
    tests_run++;
    if (got !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, e, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // The answer stands for one cycle only, so it is looked at just after the taking edge.
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", e, rdata);
  endtask : rd_reg

  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Waits for the type or the button flag, and rejects a change that came too soon.
  task automatic wait_out(input bit sel, input logic [1:0] e, input int lo, input int hi);
    int n;
    n = 0;
    while (((sel ? {1'b0, bflag} : htype) !== e) && n <= hi) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n > hi) begin
      err_total++;
      $display("Error wait expected %h seen %h", e, sel ? {1'b0, bflag} : htype);
      final_report();
    end
    chk("early change", 8'h00, {7'h00, n < lo});
  endtask : wait_out

  initial begin
    int p;
    logic [1:0] e;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    rd_reg(ADDR_OVF_PLL, 8'h01);
    rd_reg(ADDR_FILT, 8'h00);
    rd_reg(ADDR_HSD_A, 8'h00);
    chk("pll ratio", 8'h01, {3'h0, ratio});
    $display("Test reset done");
    // Writes to the flag bits must not land.
    for (int c = 0; c < 16; c++) begin
      wr_reg(ADDR_OVF_PLL, {4'hf, c[3:0]});
      repeat (2) @(posedge i_clk);
      #1;
      chk("pll ratio", (c == 0) ? 8'h10 : 8'(c), {3'h0, ratio});
      rd_reg(ADDR_OVF_PLL, {4'h0, c[3:0]});
    end
    $display("Test pll done");
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      ovf <= 4'h8 >> i;
      @(posedge i_clk);
      ovf <= 4'h0;
      repeat (3) @(posedge i_clk);
      rd_reg(ADDR_OVF_PLL, (8'h80 >> i) | 8'h0f);
      rd_reg(ADDR_OVF_PLL, 8'h0f);
    end
    $display("Test overflow done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_FILT, fv[i]);
      repeat (2) @(posedge i_clk);
      #1;
      chk("filters", fv[i], {hpf_l, hpf_r, fx_l, de_l, fx_r, de_r});
      rd_reg(ADDR_FILT, fv[i]);
    end
    wr_reg(8'h20, 8'hff);
    rd_reg(8'h20, 8'h00);
    $display("Test filter done");
    // Only the six legal jack codes are written.
    for (int c = 0; c < 6; c++) begin
      p = (2 << c) * TK;
      e = (c == 0) ? TYPE_MIC : TYPE_NO_MIC;
      wr_reg(ADDR_HSD_A, 8'h00);
      @(posedge i_clk);
      jack_req <= 1'b1;
      mic_req <= (c == 0);
      repeat (100) @(posedge i_clk);
      #1;
      chk("type disabled", 8'h00, {6'h00, htype});
      wr_reg(ADDR_HSD_A, 8'h81 | 8'(c << 2));
      wait_out(1'b0, e, 7 * p, 9 * p + 16);
      rd_reg(ADDR_HSD_A, 8'h81 | 8'(c << 2) | {1'b0, e, 5'h00});
      @(posedge i_clk);
      jack_req <= 1'b0;
      mic_req <= 1'b0;
      wait_out(1'b0, TYPE_NONE, 7 * p, 9 * p + 16);
    end
    $display("Test jack done");
    for (int b = 0; b < 4; b++) begin
      p = (b == 0) ? 0 : (1 << (b - 1)) * TK;
      wr_reg(ADDR_HSD_A, 8'h80 | 8'(b));
      @(posedge i_clk);
      btn_req <= 1'b1;
      wait_out(1'b1, 2'h1, 7 * p, 9 * p + 16);
      @(posedge i_clk);
      btn_req <= 1'b0;
      repeat (9 * p + 16) @(posedge i_clk);
      rd_reg(ADDR_HSD_B, 8'h20);
      rd_reg(ADDR_HSD_B, 8'h00);
    end
    $display("Test button done");
    final_report();
  end
endmodule : codec_flags_filter_headset_regs_tb
`default_nettype wire
